/* include/itmss_pkg.sv */
// constants and types shared by the interrupt trigger, mask, status and steering block
package itmss_pkg;

   // ==========================================================
   // widths and counts
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_LEVELS = 8;
   localparam int NUM_CTL = 2;
   localparam int NUM_LINES = 4;

   // ==========================================================
   // i/o port addresses
   localparam logic [15:0] ADDR_M_CMD = 16'h0020;
   localparam logic [15:0] ADDR_M_DATA = 16'h0021;
   localparam logic [15:0] ADDR_M_DATA_ALT = 16'h0061;
   localparam logic [15:0] ADDR_S_CMD = 16'h00A0;
   localparam logic [15:0] ADDR_S_DATA = 16'h00A1;
   localparam logic [15:0] ADDR_TSEL_M = 16'h0480;
   localparam logic [15:0] ADDR_TSEL_S = 16'h0481;
   localparam logic [15:0] ADDR_ROUTE_BASE = 16'h0490;

   // ==========================================================
   // command, route and poll byte field positions
   localparam int CMD_INIT_BIT = 4;
   localparam int INIT_W4_REQ_BIT = 0;
   localparam int OCW_SEL_BIT = 3;
   localparam int OCW2_EOI_BIT = 5;
   localparam int OCW2_SL_BIT = 6;
   localparam int STAT_SEL_BIT = 0;
   localparam int STAT_LOAD_BIT = 1;
   localparam int POLL_ARM_BIT = 2;
   localparam int SMASK_VAL_BIT = 5;
   localparam int SMASK_WE_BIT = 6;
   localparam int ROUTE_DIS_BIT = 7;
   localparam int POLL_VALID_BIT = 7;

   // ==========================================================
   // reset values, fixed bits and level codes
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] TSEL_RST = 8'h00;
   localparam logic [7:0] ROUTE_RST = 8'h80;
   localparam logic [7:0] TSEL_M_WMASK = 8'hF8;
   localparam logic [7:0] TSEL_S_WMASK = 8'hDE;
   localparam logic [15:0] ROUTE_ALLOWED = 16'hDEF8;
   localparam logic [2:0] SPUR_LVL = 3'h7;
   localparam logic [2:0] CASC_LVL = 3'h2;

   // ==========================================================
   // state types
   typedef enum logic [1:0] {INIT_DONE, INIT_W2, INIT_W3, INIT_W4} itmss_init_t;
   typedef enum logic {ACK_IDLE, ACK_SECOND} itmss_ack_t;

endpackage

/* core/itmss_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module itmss_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         meta_reg <= d_i;
         q_reg <= meta_reg;
      end
   end

   assign q_o = q_reg;
endmodule
`default_nettype wire

/* core/itmss_prio.sv */
// priority resolver for one eight-level controller
`timescale 1ns/1ps
`default_nettype none
module itmss_prio (
   // request state
   input wire logic [7:0] req_i,
   input wire logic [7:0] insvc_i,
   input wire logic [7:0] mask_i,
   input wire logic smask_i,
   // result
   output logic valid_o,
   output logic [2:0] level_o
);
   logic blocked;

   // level 0 first; unless special mask is set, an in-service level shuts itself and everything below
   always_comb begin
      valid_o = 1'b0;
      level_o = 3'h0;
      blocked = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (!valid_o && !blocked) begin
            if (!smask_i && insvc_i[i]) begin
               blocked = 1'b1;
            end else if (req_i[i] && !mask_i[i]) begin
               valid_o = 1'b1;
               level_o = 3'(i);
            end
         end
      end
   end
endmodule
`default_nettype wire

/* core/itmss_top.sv */
// cascaded interrupt controller pair: triggering, masking, status reads and line steering
`timescale 1ns/1ps
`default_nettype none
module itmss_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // i/o register port
   input wire logic [itmss_pkg::ADDR_W-1:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [itmss_pkg::DATA_W-1:0] io_wdata_i,
   output logic [itmss_pkg::DATA_W-1:0] io_rdata_o,
   // request pins
   input wire logic [15:0] irq_i,
   input wire logic [itmss_pkg::NUM_LINES-1:0] shared_pci_lines_low_i,
   // processor acknowledge side
   input wire logic acknowledge_pulse_low_i,
   output logic cpu_interrupt_out_o,
   output logic [3:0] ack_vector_o,
   output logic ack_spurious_o,
   output logic ack_valid_o
);
   import itmss_pkg::*;

   // ==========================================================
   // declarations
   logic [15:0] irq_sync;
   logic [NUM_LINES-1:0] lines_sync;
   logic [15:0] steer;
   logic [15:0] route_in;
   logic [7:0] route_reg [NUM_LINES];
   logic [7:0] tsel_reg [NUM_CTL];
   logic [7:0] ctl_in [NUM_CTL];
   logic [7:0] prev_reg [NUM_CTL];
   logic [7:0] pend_reg [NUM_CTL];
   logic [7:0] insvc_reg [NUM_CTL];
   logic [7:0] mask_reg [NUM_CTL];
   logic smask_reg [NUM_CTL];
   logic rsel_insvc_reg [NUM_CTL];
   logic poll_reg [NUM_CTL];
   itmss_init_t init_reg [NUM_CTL];
   logic ic4_reg [NUM_CTL];
   logic prio_valid [NUM_CTL];
   logic [2:0] prio_lvl [NUM_CTL];
   logic [7:0] insvc_set [NUM_CTL];
   logic [7:0] pend_clr [NUM_CTL];
   logic poll_rd [NUM_CTL];
   logic [7:0] status_rd [NUM_CTL];
   logic ack_prev_reg;
   itmss_ack_t ack_state_reg;
   logic ack_fall;
   logic ack_first;
   logic [3:0] vec_next;
   logic spur_next;
   logic [7:0] rdata_next;

   // ==========================================================
   // pin synchronisers
   // request pins and shared lines come from outside the clock domain
   itmss_sync #(.WIDTH(16), .RST_VAL(16'h0000)) u_irq_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(irq_i),
      .q_o(irq_sync)
   );

   // idle level of an active-low line is high
   itmss_sync #(.WIDTH(NUM_LINES), .RST_VAL(4'hF)) u_line_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(shared_pci_lines_low_i),
      .q_o(lines_sync)
   );

   // ==========================================================
   // shared line steering
   // route registers, one per shared line
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < NUM_LINES; k++) begin
            route_reg[k] <= ROUTE_RST;
         end
      end else if (io_wr_i && io_addr_i[15:2] == ADDR_ROUTE_BASE[15:2]) begin
         route_reg[io_addr_i[1:0]] <= io_wdata_i;
      end
   end

   // an active-low line drives its chosen input high; several lines may share one
   always_comb begin
      steer = 16'h0000;
      for (int k = 0; k < NUM_LINES; k++) begin
         if (!route_reg[k][ROUTE_DIS_BIT]
             && ROUTE_ALLOWED[route_reg[k][3:0]]
             && !lines_sync[k]) begin
            steer[route_reg[k][3:0]] = 1'b1;
         end
      end
   end

   assign route_in = irq_sync | steer;

   // slave output drives master input 2, so master mask bit 2 gates the whole slave
   assign ctl_in[0] = {route_in[7:3], prio_valid[1], route_in[1:0]};
   assign ctl_in[1] = route_in[15:8];

   // ==========================================================
   // per controller state
   genvar c;
   for (c = 0; c < NUM_CTL; c++) begin : g_ctl
      logic [15:0] cmd_addr;
      logic [15:0] data_addr;
      logic [15:0] tsel_addr;
      logic [7:0] tsel_wmask;
      logic wr_cmd;
      logic wr_data;
      logic init_wr;
      logic ocw2;
      logic op3_wr;
      logic [7:0] eoi_cand;
      logic [7:0] eoi_clr;
      logic [7:0] rise;

      assign cmd_addr = (c == 0) ? ADDR_M_CMD : ADDR_S_CMD;
      assign data_addr = (c == 0) ? ADDR_M_DATA : ADDR_S_DATA;
      assign tsel_addr = (c == 0) ? ADDR_TSEL_M : ADDR_TSEL_S;
      assign tsel_wmask = (c == 0) ? TSEL_M_WMASK : TSEL_S_WMASK;
      assign wr_cmd = io_wr_i && io_addr_i == cmd_addr;
      assign wr_data = io_wr_i && io_addr_i == data_addr;
      assign init_wr = wr_cmd && io_wdata_i[CMD_INIT_BIT];
      assign ocw2 = wr_cmd && !io_wdata_i[CMD_INIT_BIT] && !io_wdata_i[OCW_SEL_BIT];
      assign op3_wr = wr_cmd && !io_wdata_i[CMD_INIT_BIT] && io_wdata_i[OCW_SEL_BIT];
      assign poll_rd[c] = io_rd_i && io_addr_i == cmd_addr && poll_reg[c];
      assign status_rd[c] = rsel_insvc_reg[c] ? insvc_reg[c] : pend_reg[c];
      assign rise = ctl_in[c] & ~prev_reg[c];

      // non-specific end picks the highest-priority in-service bit; masked ones stay
      // under special mask mode so a routine can hold its own level
      assign eoi_cand = insvc_reg[c] & ~(smask_reg[c] ? mask_reg[c] : 8'h00);
      always_comb begin
         eoi_clr = 8'h00;
         if (ocw2 && io_wdata_i[OCW2_EOI_BIT]) begin
            if (io_wdata_i[OCW2_SL_BIT]) begin
               eoi_clr[io_wdata_i[2:0]] = 1'b1;
            end else begin
               eoi_clr = eoi_cand & (~eoi_cand + 8'h01);
            end
         end
      end

      // trigger-select register; fixed-edge bits never take a one
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            tsel_reg[c] <= TSEL_RST;
         end else if (io_wr_i && io_addr_i == tsel_addr) begin
            tsel_reg[c] <= io_wdata_i & tsel_wmask;
         end
      end

      // request register: edge latch or live level, never gated by the mask
      // an edge request also drops if its line falls before acknowledge
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            prev_reg[c] <= 8'h00;
            pend_reg[c] <= 8'h00;
         end else begin
            prev_reg[c] <= ctl_in[c];
            for (int i = 0; i < 8; i++) begin
               if (tsel_reg[c][i]) begin
                  pend_reg[c][i] <= ctl_in[c][i];
               end else begin
                  pend_reg[c][i] <= rise[i]
                     | (pend_reg[c][i] & ~pend_clr[c][i] & ctl_in[c][i]);
               end
            end
         end
      end

      // in-service register; a new acknowledge wins over an end command
      always_ff @(posedge clk_i) begin
         if (rst_i || init_wr) begin
            insvc_reg[c] <= 8'h00;
         end else begin
            insvc_reg[c] <= (insvc_reg[c] & ~eoi_clr) | insvc_set[c];
         end
      end

      // mask register and init sequencing; legacy level bit is not looked at
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            mask_reg[c] <= MASK_RST;
            init_reg[c] <= INIT_DONE;
            ic4_reg[c] <= 1'b0;
         end else if (init_wr) begin
            mask_reg[c] <= MASK_RST;
            init_reg[c] <= INIT_W2;
            ic4_reg[c] <= io_wdata_i[INIT_W4_REQ_BIT];
         end else if (wr_data) begin
            unique case (init_reg[c])
               INIT_DONE: mask_reg[c] <= io_wdata_i;
               INIT_W2: init_reg[c] <= INIT_W3;
               INIT_W3: init_reg[c] <= ic4_reg[c] ? INIT_W4 : INIT_DONE;
               INIT_W4: init_reg[c] <= INIT_DONE;
            endcase
         end
      end

      // mode, status select and poll arming from the third operation word
      always_ff @(posedge clk_i) begin
         if (rst_i || init_wr) begin
            smask_reg[c] <= 1'b0;
            rsel_insvc_reg[c] <= 1'b0;
            poll_reg[c] <= 1'b0;
         end else if (op3_wr) begin
            if (io_wdata_i[SMASK_WE_BIT]) begin
               smask_reg[c] <= io_wdata_i[SMASK_VAL_BIT];
            end
            if (io_wdata_i[STAT_LOAD_BIT]) begin
               rsel_insvc_reg[c] <= io_wdata_i[STAT_SEL_BIT];
            end
            poll_reg[c] <= io_wdata_i[POLL_ARM_BIT];
         end else if (poll_rd[c]) begin
            poll_reg[c] <= 1'b0;
         end
      end

      itmss_prio u_prio (
         .req_i(pend_reg[c]),
         .insvc_i(insvc_reg[c]),
         .mask_i(mask_reg[c]),
         .smask_i(smask_reg[c]),
         .valid_o(prio_valid[c]),
         .level_o(prio_lvl[c])
      );
   end

   // ==========================================================
   // acknowledge sequence
   assign ack_fall = ack_prev_reg && !acknowledge_pulse_low_i;
   assign ack_first = ack_fall && ack_state_reg == ACK_IDLE;

   // two falling edges make one acknowledge; the level is resolved at the first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_prev_reg <= 1'b1;
         ack_state_reg <= ACK_IDLE;
      end else begin
         ack_prev_reg <= acknowledge_pulse_low_i;
         if (ack_fall) begin
            unique case (ack_state_reg)
               ACK_IDLE: ack_state_reg <= ACK_SECOND;
               ACK_SECOND: ack_state_reg <= ACK_IDLE;
            endcase
         end
      end
   end

   // in-service marking and request clearing for acknowledge and poll reads
   always_comb begin
      for (int k = 0; k < NUM_CTL; k++) begin
         insvc_set[k] = 8'h00;
         pend_clr[k] = 8'h00;
      end
      vec_next = 4'h0;
      spur_next = 1'b0;
      if (ack_first) begin
         if (!prio_valid[0]) begin
            vec_next = {1'b0, SPUR_LVL};
            spur_next = 1'b1;
         end else if (prio_lvl[0] == CASC_LVL) begin
            insvc_set[0][CASC_LVL] = 1'b1;
            pend_clr[0][CASC_LVL] = 1'b1;
            if (prio_valid[1]) begin
               insvc_set[1][prio_lvl[1]] = 1'b1;
               pend_clr[1][prio_lvl[1]] = 1'b1;
               vec_next = {1'b1, prio_lvl[1]};
            end else begin
               vec_next = {1'b1, SPUR_LVL};
               spur_next = 1'b1;
            end
         end else begin
            insvc_set[0][prio_lvl[0]] = 1'b1;
            pend_clr[0][prio_lvl[0]] = 1'b1;
            vec_next = {1'b0, prio_lvl[0]};
         end
      end
      // a poll read acts as an acknowledge inside its own controller
      for (int k = 0; k < NUM_CTL; k++) begin
         if (poll_rd[k] && prio_valid[k]) begin
            insvc_set[k][prio_lvl[k]] = 1'b1;
            pend_clr[k][prio_lvl[k]] = 1'b1;
         end
      end
   end

   // vector outputs hold until the next acknowledge; valid is a one-cycle pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_vector_o <= 4'h0;
         ack_spurious_o <= 1'b0;
         ack_valid_o <= 1'b0;
      end else begin
         ack_valid_o <= ack_first;
         if (ack_first) begin
            ack_vector_o <= vec_next;
            ack_spurious_o <= spur_next;
         end
      end
   end

   // processor request line follows the master resolver, one cycle late
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_interrupt_out_o <= 1'b0;
      end else begin
         cpu_interrupt_out_o <= prio_valid[0];
      end
   end

   // ==========================================================
   // read data
   // unmapped addresses read as zero; poll overrides the status select
   always_comb begin
      rdata_next = 8'h00;
      unique case (io_addr_i)
         ADDR_M_CMD: rdata_next = poll_reg[0]
            ? {prio_valid[0], 4'h0, prio_lvl[0]} : status_rd[0];
         ADDR_S_CMD: rdata_next = poll_reg[1]
            ? {prio_valid[1], 4'h0, prio_lvl[1]} : status_rd[1];
         ADDR_M_DATA, ADDR_M_DATA_ALT: rdata_next = mask_reg[0];
         ADDR_S_DATA: rdata_next = mask_reg[1];
         ADDR_TSEL_M: rdata_next = tsel_reg[0];
         ADDR_TSEL_S: rdata_next = tsel_reg[1];
         default: begin
            if (io_addr_i[15:2] == ADDR_ROUTE_BASE[15:2]) begin
               rdata_next = route_reg[io_addr_i[1:0]];
            end
         end
      endcase
   end

   // read data is captured on the read strobe and held until the next read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         io_rdata_o <= 8'h00;
      end else if (io_rd_i) begin
         io_rdata_o <= rdata_next;
      end
   end

endmodule
`default_nettype wire

/* dv/itmss_top_sva.sv */
// assertion checker for the interrupt trigger, mask, status and steering block
`timescale 1ns/1ps
`default_nettype none
module itmss_top_sva (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [itmss_pkg::ADDR_W-1:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [itmss_pkg::DATA_W-1:0] io_wdata_i,
   input wire logic [itmss_pkg::DATA_W-1:0] io_rdata_o,
   // request pins
   input wire logic [15:0] irq_i,
   input wire logic [itmss_pkg::NUM_LINES-1:0] shared_pci_lines_low_i,
   // acknowledge side
   input wire logic acknowledge_pulse_low_i,
   input wire logic cpu_interrupt_out_o,
   input wire logic [3:0] ack_vector_o,
   input wire logic ack_spurious_o,
   input wire logic ack_valid_o
);
   import itmss_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ==========================================================
   // master mask shadow; init word clears it and swallows the next data writes
   logic [7:0] mask_exp;
   logic [1:0] skip_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_exp <= MASK_RST;
         skip_cnt <= 2'h0;
      end else if (io_wr_i && io_addr_i == ADDR_M_CMD && io_wdata_i[CMD_INIT_BIT]) begin
         mask_exp <= MASK_RST;
         skip_cnt <= io_wdata_i[INIT_W4_REQ_BIT] ? 2'h3 : 2'h2;
      end else if (io_wr_i && io_addr_i == ADDR_M_DATA) begin
         if (skip_cnt != 2'h0) begin
            skip_cnt <= skip_cnt - 2'h1;
         end else begin
            mask_exp <= io_wdata_i;
         end
      end
   end

   // ==========================================================
   // acknowledge answers
   a_ack_one_pulse: assert property (ack_valid_o |=> !ack_valid_o)
      else $error("acknowledge valid longer than one cycle");
   a_ack_after_fall: assert property (ack_valid_o |->
      $past(acknowledge_pulse_low_i, 2) && !$past(acknowledge_pulse_low_i))
      else $error("acknowledge answer without a fall before it");
   a_spur_is_seven: assert property (ack_valid_o && ack_spurious_o |->
      ack_vector_o[2:0] == SPUR_LVL)
      else $error("spurious answer not at level seven");
   a_vector_held: assert property (!ack_valid_o |->
      $stable(ack_vector_o) && $stable(ack_spurious_o))
      else $error("acknowledge result changed without valid");
   a_no_cascade_vec: assert property (ack_valid_o |-> ack_vector_o != {1'b0, CASC_LVL})
      else $error("cascade input given as a vector");

   // ==========================================================
   // register reads
   a_rdata_hold: assert property (!$past(io_rd_i) |-> $stable(io_rdata_o))
      else $error("read data changed without a read");
   a_mask_readback: assert property (io_rd_i &&
      (io_addr_i == ADDR_M_DATA || io_addr_i == ADDR_M_DATA_ALT) |=>
      io_rdata_o == $past(mask_exp))
      else $error("mask read returned wrong value");
   a_tsel_m_fixed: assert property (io_rd_i && io_addr_i == ADDR_TSEL_M |=>
      (io_rdata_o & ~TSEL_M_WMASK) == 8'h00)
      else $error("fixed master trigger bits not zero");
   a_tsel_s_fixed: assert property (io_rd_i && io_addr_i == ADDR_TSEL_S |=>
      (io_rdata_o & ~TSEL_S_WMASK) == 8'h00)
      else $error("fixed slave trigger bits not zero");
endmodule
bind itmss_top itmss_top_sva u_sva (.clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i,
   .io_wdata_i, .io_rdata_o, .irq_i, .shared_pci_lines_low_i, .acknowledge_pulse_low_i,
   .cpu_interrupt_out_o, .ack_vector_o, .ack_spurious_o, .ack_valid_o);
`default_nettype wire

/* dv/itmss_cpu_model.sv */
// processor model issuing two-pulse acknowledge sequences
`timescale 1ns/1ps
`default_nettype none
module itmss_cpu_model (
   // clock
   input wire logic clk_i,
   // control from bench
   input wire logic go_i,
   input wire logic slow_i,
   // acknowledge line
   output logic ack_low_o,
   output logic busy_o
);
   int cnt = 0;
   int len = 2;
   initial ack_low_o = 1'b1;
   // sequence counter; low phases never shorter than two cycles
   always @(posedge clk_i) begin
      if (cnt == 0 && go_i) begin
         cnt <= 1;
         len <= slow_i ? 4 : 2;
      end else if (cnt != 0) begin
         cnt <= (cnt == 4 * len) ? 0 : cnt + 1;
      end
   end
   // drive off the sampling edge so the fall is seen cleanly
   always @(negedge clk_i) begin
      ack_low_o <= !((cnt >= 1 && cnt <= len) || (cnt > 2 * len && cnt <= 3 * len));
   end
   assign busy_o = (cnt != 0);
endmodule
`default_nettype wire

/* dv/itmss_top_tb.sv */
// self-checking bench for the interrupt trigger, mask, status and steering block
`timescale 1ns/1ps
`default_nettype none
module itmss_top_tb;
   import itmss_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [15:0] io_addr_i = '0;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [7:0] io_wdata_i = '0;
   logic [7:0] io_rdata_o;
   logic [15:0] irq_i = '0;
   logic [3:0] pci_low = 4'hF;
   logic go = 1'b0;
   logic slow = 1'b0;
   logic ack_low;
   logic busy;
   logic cpu_int;
   logic ack_spur;
   logic ack_valid;
   logic [3:0] ack_vec;
   logic [7:0] m;
   logic [3:0] dest;
   logic [3:0] allowed [11] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;

   itmss_top dut (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
      .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .irq_i(irq_i),
      .shared_pci_lines_low_i(pci_low), .acknowledge_pulse_low_i(ack_low),
      .cpu_interrupt_out_o(cpu_int), .ack_vector_o(ack_vec), .ack_spurious_o(ack_spur),
      .ack_valid_o(ack_valid));
   itmss_cpu_model u_cpu (.clk_i(clk_i), .go_i(go), .slow_i(slow), .ack_low_o(ack_low),
      .busy_o(busy));

   // ==========================================================
   // clock and hang guard
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   // ==========================================================
   // helpers; all drivers change at the falling edge
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = 1'b1;
      tick(1);
      io_wr_i = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      io_addr_i = a;
      io_rd_i = 1'b1;
      tick(1);
      io_rd_i = 1'b0;
      tick(1);
      chk(io_rdata_o, exp);
   endtask
   task automatic exp_int(input logic e);
      tick(8);
      chk({7'h0, cpu_int}, {7'h0, e});
   endtask
   task automatic eoi();
      wr(ADDR_S_CMD, 8'h20);
      wr(ADDR_M_CMD, 8'h20);
   endtask
   // one full acknowledge pair at random speed, then compare the answer
   task automatic ack(input logic [3:0] v, input logic s);
      int i;
      // a fresh pin needs three cycles to reach the resolver; a processor answers later still
      tick(8);
      slow = 1'($urandom % 2);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (i = 0; i < 40 && ack_valid !== 1'b1; i++) tick(1);
      chk({7'h0, ack_valid}, 8'h01);
      chk({4'h0, ack_vec}, {4'h0, v});
      chk({7'h0, ack_spur}, {7'h0, s});
      for (i = 0; i < 40 && busy === 1'b1; i++) tick(1);
      tick(2);
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'hAF4A));
      tick(10);
      rst_i = 1'b0;
      tick(2);
      rd(ADDR_M_DATA, MASK_RST);
      rd(ADDR_TSEL_M, TSEL_RST);
      rd(ADDR_ROUTE_BASE, ROUTE_RST);
      rd(ADDR_M_CMD, 8'h00);
      // init word with the legacy level bit set; data writes are swallowed
      wr(ADDR_M_CMD, 8'h19);
      wr(ADDR_M_DATA, 8'h08);
      wr(ADDR_M_DATA, 8'h04);
      wr(ADDR_M_DATA, 8'h01);
      rd(ADDR_M_DATA, 8'h00);
      repeat (4) begin
         m = 8'($urandom);
         wr(ADDR_M_DATA, m);
         rd(ADDR_M_DATA_ALT, m);
      end
      wr(ADDR_M_DATA, 8'h00);
      wr(ADDR_TSEL_M, 8'hFF);
      rd(ADDR_TSEL_M, 8'hF8);
      wr(ADDR_TSEL_S, 8'hFF);
      rd(ADDR_TSEL_S, 8'hDE);
      wr(ADDR_TSEL_M, 8'h00);
      wr(ADDR_TSEL_S, 8'h00);
      // edge input held high raises one request only
      irq_i[3] = 1'b1;
      exp_int(1'b1);
      ack(4'h3, 1'b0);
      eoi();
      exp_int(1'b0);
      irq_i[3] = 1'b0;
      // level input re-requests while high
      wr(ADDR_TSEL_M, 8'h10);
      irq_i[4] = 1'b1;
      ack(4'h4, 1'b0);
      eoi();
      exp_int(1'b1);
      ack(4'h4, 1'b0);
      irq_i[4] = 1'b0;
      tick(4);
      eoi();
      exp_int(1'b0);
      wr(ADDR_TSEL_M, 8'h00);
      // request gone before the acknowledge
      irq_i[5] = 1'b1;
      exp_int(1'b1);
      irq_i[5] = 1'b0;
      tick(4);
      ack(4'h7, 1'b1);
      wr(ADDR_M_CMD, 8'h0B);
      rd(ADDR_M_CMD, 8'h00);
      irq_i[7] = 1'b1;
      ack(4'h7, 1'b0);
      rd(ADDR_M_CMD, 8'h80);
      rd(ADDR_M_CMD, 8'h80);
      irq_i[7] = 1'b0;
      wr(ADDR_M_CMD, 8'h67); // specific end for level 7
      rd(ADDR_M_CMD, 8'h00);
      wr(ADDR_M_CMD, 8'h0A);
      // masked request still pending in the request register
      wr(ADDR_M_DATA, 8'h08);
      irq_i[3] = 1'b1;
      exp_int(1'b0);
      rd(ADDR_M_CMD, 8'h08);
      wr(ADDR_M_DATA, 8'h00);
      exp_int(1'b1);
      ack(4'h3, 1'b0);
      rd(ADDR_M_CMD, 8'h00);
      irq_i[3] = 1'b0;
      eoi();
      // cascade input masked blocks the slave
      wr(ADDR_M_DATA, 8'h04);
      irq_i[10] = 1'b1;
      exp_int(1'b0);
      wr(ADDR_M_DATA, 8'h00);
      ack(4'hA, 1'b0);
      irq_i[10] = 1'b0;
      eoi();
      // two requests together: lower number wins
      irq_i[5] = 1'b1;
      irq_i[3] = 1'b1;
      ack(4'h3, 1'b0);
      eoi();
      ack(4'h5, 1'b0);
      eoi();
      irq_i[5] = 1'b0;
      irq_i[3] = 1'b0;
      // in-service blocking, then special mask mode
      irq_i[4] = 1'b1;
      ack(4'h4, 1'b0);
      irq_i[6] = 1'b1;
      exp_int(1'b0);
      wr(ADDR_M_CMD, 8'h68);
      exp_int(1'b1);
      wr(ADDR_M_DATA, 8'h40);
      exp_int(1'b0);
      wr(ADDR_M_DATA, 8'h00);
      wr(ADDR_M_CMD, 8'h48);
      exp_int(1'b0);
      eoi();
      ack(4'h6, 1'b0);
      eoi();
      irq_i[4] = 1'b0;
      irq_i[6] = 1'b0;
      // poll read in place of the status register
      irq_i[3] = 1'b1;
      tick(8);
      wr(ADDR_M_CMD, 8'h0C);
      rd(ADDR_M_CMD, 8'h83);
      irq_i[3] = 1'b0;
      tick(4);
      eoi();
      // shared lines steered to random allowed inputs
      wr(ADDR_TSEL_M, 8'hF8);
      wr(ADDR_TSEL_S, 8'hDE);
      for (int k = 0; k < 4; k++) begin
         dest = allowed[$urandom % 11];
         wr(ADDR_ROUTE_BASE + 16'(k), {4'h0, dest});
         pci_low[k] = 1'b0;
         exp_int(1'b1);
         ack(dest, 1'b0);
         pci_low[k] = 1'b1;
         tick(4);
         eoi();
         wr(ADDR_ROUTE_BASE + 16'(k), {4'h8, dest});
         pci_low[k] = 1'b0;
         exp_int(1'b0);
         wr(ADDR_ROUTE_BASE + 16'(k), 8'h0D);
         exp_int(1'b0);
         pci_low[k] = 1'b1;
         wr(ADDR_ROUTE_BASE + 16'(k), ROUTE_RST);
      end
      stop_test();
   end
endmodule
`default_nettype wire
